// File: shared/oft_defines.svh
// Offsets, field positions, reset values and timing counts for the clock block
`ifndef OFT_DEFINES_SVH
`define OFT_DEFINES_SVH

// Register byte offsets
`define OFT_OFF_FREQ_SEL      12'h000
`define OFT_OFF_THROTTLE      12'h004
`define OFT_OFF_STATUS        12'h008

// Frequency select fields
`define OFT_FRQ_LSB           0
`define OFT_FRQ_W             3
`define OFT_FRQ_RST_1MHZ_CFG  3'h6
`define OFT_FRQ_RST_32MHZ_CFG 3'h0
`define OFT_FRQ_RST_AFTER_1   3'h2
`define OFT_FRQ_RST_AFTER_32  3'h6
`define OFT_FRQ_RST_OTHER     3'h2
`define OFT_FRQ_RESERVED      3'h7

// Throttle control fields
`define OFT_THR_RATIO_LSB     0
`define OFT_THR_RATIO_W       3
`define OFT_THR_EN_BIT        4
`define OFT_THR_WAKE_BIT      5

// Phases per instruction cycle
`define OFT_PHASES            4

`endif

// File: shared/oft_pkg.sv
// Types for the oscillator select and CPU throttle block
package oft_pkg;

   typedef enum logic [1:0] {
      OFT_RUN      = 2'b00,
      OFT_THROTTLE = 2'b01,
      OFT_IDLE     = 2'b10,
      OFT_SLEEP    = 2'b11
   } oft_mode_e;

   typedef logic [2:0] oft_code_t;

   // Nominal MHz for a frequency code, zero for the reserved code
   function automatic logic [5:0] oft_freq_mhz(input oft_code_t code);
      unique case (code)
         3'h6:    oft_freq_mhz = 6'h20;
         3'h5:    oft_freq_mhz = 6'h10;
         3'h4:    oft_freq_mhz = 6'h0C;
         3'h3:    oft_freq_mhz = 6'h08;
         3'h2:    oft_freq_mhz = 6'h04;
         3'h1:    oft_freq_mhz = 6'h02;
         3'h0:    oft_freq_mhz = 6'h01;
         default: oft_freq_mhz = 6'h00;
      endcase
   endfunction

endpackage

// File: core/oft_phase_gen.sv
// Phase generator and instruction-cycle throttle counter
`timescale 1ns/100ps
`include "oft_defines.svh"
module oft_phase_gen
   import oft_pkg::*;
#(
   parameter int RATIO_W = 3
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // Control
   input  wire logic               throttle_en,
   input  wire logic [RATIO_W-1:0] ratio_code,
   input  wire logic               wake_evt,
   // Outputs
   output logic [1:0]              phase,
   output logic                    cycle_end,
   output logic                    exec_slot
);

   logic [1:0] phase_r;
   logic [1:0] phase_nxt;
   logic [7:0] skip_r;
   logic [7:0] skip_nxt;
   logic [7:0] skip_last;

   // Ratio 1:2^(code+1): 001 gives 1:4, 100 gives 1:32
   assign skip_last = 8'((9'h002 << ratio_code) - 9'h001);
   assign cycle_end = (phase_r == 2'(`OFT_PHASES - 1));
   assign phase     = phase_r;
   // Slot zero executes; throttle off executes every cycle
   assign exec_slot = !throttle_en || (skip_r == 8'h00);

   always_comb begin
      phase_nxt = 2'(phase_r + 2'h1);
      skip_nxt  = skip_r;
      if (!throttle_en || wake_evt) begin
         skip_nxt = 8'h00;
      end else if (cycle_end) begin
         skip_nxt = (skip_r >= skip_last) ? 8'h00
                                          : 8'(skip_r + 8'h01);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase_r <= 2'h0;
         skip_r  <= 8'h00;
      end else begin
         phase_r <= phase_nxt;
         skip_r  <= skip_nxt;
      end
   end

endmodule

// File: core/oft_clock_ctrl.sv
// Oscillator frequency select and CPU throttle control with APB registers
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`include "oft_defines.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Decode 3-bit frequency code; 111 reserved
// - Reset config 110 loads frequency code 010
// - Reset config 000 loads frequency code 110
// - Three power-down modes: throttle, idle, sleep
// - In throttle, oscillators keep running; only CPU slowed
// - Throttle on: execute one cycle of N
// - Ratio code 100 gives one run, 31 idle
// - Ratio code 001 gives 1:4
// - Peripherals keep full clock while CPU skips
// - Flash still fetches; phase clocks never stop
// - Wake-on-interrupt bit shares throttle register
module oft_clock_ctrl
   import oft_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Reset-time configuration
   input  wire logic [2:0]  reset_osc_config,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Power-mode requests and interrupt from the core
   input  wire logic        idle_req,
   input  wire logic        sleep_req,
   input  wire logic        irq_pending,
   // Clock consumers
   output logic             osc_run,
   output logic [2:0]       hf_freq_code,
   output logic [5:0]       hf_freq_mhz,
   output logic             cpu_clk_en,
   output logic             flash_fetch_en,
   output logic             periph_clk_en,
   output logic [1:0]       periph_phase,
   output logic [1:0]       power_mode
);

   //////////////////////////////////////////////////////////////////////////
   // Registers
   logic [2:0]  freq_r;
   logic [2:0]  freq_nxt;
   logic [2:0]  ratio_r;
   logic [2:0]  ratio_nxt;
   logic        thr_en_r;
   logic        thr_en_nxt;
   logic        wake_r;
   logic        wake_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic        err_r;
   logic        err_nxt;
   logic        rst_d_r;
   oft_mode_e   mode_r;
   oft_mode_e   mode_nxt;

   logic        wr_en;
   logic        rd_en;
   logic        wake_evt;
   logic [1:0]  phase;
   logic        cycle_end;
   logic        exec_slot;

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == `OFT_OFF_FREQ_SEL) || (a == `OFT_OFF_THROTTLE)
              || (a == `OFT_OFF_STATUS);
   endfunction

   // Default code for the reset oscillator configuration
   function automatic logic [2:0] rst_freq(input logic [2:0] cfg);
      if (cfg == `OFT_FRQ_RST_1MHZ_CFG)
         rst_freq = `OFT_FRQ_RST_AFTER_1;
      else if (cfg == `OFT_FRQ_RST_32MHZ_CFG)
         rst_freq = `OFT_FRQ_RST_AFTER_32;
      else
         rst_freq = `OFT_FRQ_RST_OTHER;
   endfunction

   // Read data and error load in the setup cycle, so that with no wait
   // state they stand from flip-flops at the access edge; status is thus
   // one cycle old when it is taken
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign prdata = rdata_r;
   assign pslverr = err_r;
   assign wake_evt = wake_r && irq_pending && (mode_r == OFT_THROTTLE);

   //////////////////////////////////////////////////////////////////////////
   // Register file; reset default applied the cycle after release,
   // since a strap must not load under reset itself
   always_comb begin
      freq_nxt   = freq_r;
      ratio_nxt  = ratio_r;
      thr_en_nxt = thr_en_r;
      wake_nxt   = wake_r;
      err_nxt    = 1'b0;
      rdata_nxt  = rdata_r;
      if (rst_d_r) begin
         freq_nxt = rst_freq(reset_osc_config);
      end else if (wr_en && paddr == `OFT_OFF_FREQ_SEL) begin
         freq_nxt = pwdata[`OFT_FRQ_LSB +: `OFT_FRQ_W];
      end
      if (wr_en && paddr == `OFT_OFF_THROTTLE) begin
         ratio_nxt  = pwdata[`OFT_THR_RATIO_LSB +: `OFT_THR_RATIO_W];
         thr_en_nxt = pwdata[`OFT_THR_EN_BIT];
         wake_nxt   = pwdata[`OFT_THR_WAKE_BIT];
      end
      // Wake on interrupt drops out of throttling
      if (wake_evt && !(wr_en && paddr == `OFT_OFF_THROTTLE)) begin
         thr_en_nxt = 1'b0;
      end
      if (psel && !penable) begin
         err_nxt = !addr_hit(paddr);
      end
      if (rd_en) begin
         unique case (paddr)
            `OFT_OFF_FREQ_SEL: rdata_nxt = {29'h0, freq_r};
            `OFT_OFF_THROTTLE: rdata_nxt = {26'h0, wake_r, thr_en_r,
                                            1'b0, ratio_r};
            `OFT_OFF_STATUS:   rdata_nxt = {24'h0, exec_slot, 1'b0,
                                            phase, 2'h0, mode_r};
            default:           rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         freq_r   <= 3'h0;
         ratio_r  <= 3'h0;
         thr_en_r <= 1'b0;
         wake_r   <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         err_r    <= 1'b0;
         rst_d_r  <= 1'b1;
      end else begin
         freq_r   <= freq_nxt;
         ratio_r  <= ratio_nxt;
         thr_en_r <= thr_en_nxt;
         wake_r   <= wake_nxt;
         rdata_r  <= rdata_nxt;
         err_r    <= err_nxt;
         rst_d_r  <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Power mode: sleep over idle over throttle
   always_comb begin
      if (sleep_req)
         mode_nxt = OFT_SLEEP;
      else if (idle_req)
         mode_nxt = OFT_IDLE;
      else if (thr_en_nxt)
         mode_nxt = OFT_THROTTLE;
      else
         mode_nxt = OFT_RUN;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         mode_r <= OFT_RUN;
      else
         mode_r <= mode_nxt;
   end

   oft_phase_gen #(
      .RATIO_W (3)
   ) u_phase (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .throttle_en (thr_en_r),
      .ratio_code  (ratio_r),
      .wake_evt    (wake_evt),
      .phase       (phase),
      .cycle_end   (cycle_end),
      .exec_slot   (exec_slot)
   );

   //////////////////////////////////////////////////////////////////////////
   // Clock consumers
   assign osc_run        = (mode_r != OFT_SLEEP);
   assign hf_freq_code   = freq_r;
   assign hf_freq_mhz    = oft_freq_mhz(freq_r);
   assign cpu_clk_en     = (mode_r == OFT_RUN)
                        || (mode_r == OFT_THROTTLE && exec_slot);
   // Fetch keeps running in throttle so the next slot is primed
   assign flash_fetch_en = (mode_r == OFT_RUN)
                        || (mode_r == OFT_THROTTLE);
   assign periph_clk_en  = (mode_r != OFT_SLEEP);
   assign periph_phase   = phase;
   assign power_mode     = mode_r;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   // Frequency select and straps
   a_freq_strap_load: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rst_d_r && reset_osc_config == 3'h6 |=> freq_r == 3'h2)
      else $error("1 MHz strap did not load code 010");
   a_freq_strap_hi: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rst_d_r && reset_osc_config == 3'h0 |=> freq_r == 3'h6)
      else $error("32 MHz strap did not load code 110");
   a_freq_write: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !rst_d_r && wr_en && paddr == `OFT_OFF_FREQ_SEL
      |=> freq_r == $past(pwdata[2:0]))
      else $error("frequency code write lost");
   a_freq_32mhz: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      freq_r == 3'h6 |-> hf_freq_mhz == 6'h20)
      else $error("code 110 not decoded as 32 MHz");
   a_freq_12mhz: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      freq_r == 3'h4 |-> hf_freq_mhz == 6'h0C)
      else $error("code 100 not decoded as 12 MHz");
   a_freq_reserved: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      freq_r == 3'h7 |-> hf_freq_mhz == 6'h00)
      else $error("reserved code decoded as a frequency");
   a_read_freq: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rd_en && paddr == `OFT_OFF_FREQ_SEL
      |=> prdata == {29'h0, $past(freq_r)})
      else $error("frequency code read back wrong");

   // Throttle ratio and execute slots; a cleared enable or a new ratio
   // ends what a window promises
   a_phase_runs: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      cycle_end |=> phase == 2'h0 ##1 phase == 2'h1)
      else $error("phase clock stalled");
   a_ratio_quarter: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE && ratio_r == 3'h1 && cycle_end && exec_slot
      && !wake_evt |=> (!exec_slot || !thr_en_r) [*4])
      else $error("1:4 ratio skipped too few cycles");
   a_quarter_period: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE && ratio_r == 3'h1 && cycle_end && exec_slot
      |=> ##12 (exec_slot || ratio_r != 3'h1 || !thr_en_r))
      else $error("1:4 ratio did not execute again");
   a_ratio_thirty: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE && ratio_r == 3'h4 && cycle_end && exec_slot
      |=> (!exec_slot || !thr_en_r) [*8])
      else $error("1:32 ratio skipped too few cycles");
   a_thirty_period: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE && ratio_r == 3'h4 && cycle_end && exec_slot
      |=> ##124 (exec_slot || ratio_r != 3'h4 || !thr_en_r))
      else $error("1:32 ratio did not execute after 31 idle");
   a_skip_gated: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE && !exec_slot |-> !cpu_clk_en)
      else $error("cpu ran in a skipped cycle");
   a_run_every_cycle: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_RUN |-> cpu_clk_en && flash_fetch_en)
      else $error("cpu gated with throttle off");
   a_throttle_write: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      wr_en && paddr == `OFT_OFF_THROTTLE |=> wake_r == $past(pwdata[5])
      && thr_en_r == $past(pwdata[4]) && ratio_r == $past(pwdata[2:0]))
      else $error("throttle register write lost");
   a_throttle_read: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rd_en && paddr == `OFT_OFF_THROTTLE
      |=> prdata[5:4] == {$past(wake_r), $past(thr_en_r)})
      else $error("throttle bits read back wrong");
   a_wake_exit: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      wake_evt && !wr_en |=> !thr_en_r)
      else $error("wake on interrupt ignored");
   a_wake_mode: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      wake_evt && !wr_en |=> mode_r != OFT_THROTTLE)
      else $error("still throttled after wake");

   // Power modes and clock consumers
   a_periph_throttle: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE |-> periph_clk_en && osc_run)
      else $error("peripheral clock stopped while throttled");
   a_osc_throttle: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE |-> osc_run)
      else $error("oscillator stopped while throttled");
   a_fetch_throttle: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_THROTTLE |-> flash_fetch_en)
      else $error("fetch stopped while throttled");
   a_idle_mode: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      idle_req && !sleep_req
      |=> power_mode == 2'b10 && !cpu_clk_en && periph_clk_en)
      else $error("idle request not honoured");
   a_sleep_mode: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      sleep_req |=> power_mode == 2'b11 && !cpu_clk_en)
      else $error("sleep request not honoured");
   a_sleep_osc: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      mode_r == OFT_SLEEP |-> !osc_run && !flash_fetch_en)
      else $error("oscillator or fetch running in sleep");
   a_status_read: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      rd_en && paddr == `OFT_OFF_STATUS |=> prdata[1:0] == $past(mode_r))
      else $error("status mode read back wrong");

endmodule

// File: tb/oft_core_model.sv
// Core, flash and peripheral consumer model for the clock block
`timescale 1ns/100ps
module oft_core_model (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Enables from the block
   input  wire logic        cpu_clk_en,
   input  wire logic        flash_fetch_en,
   input  wire logic        periph_clk_en,
   // Bench commands
   input  wire logic        want_idle,
   input  wire logic        want_sleep,
   input  wire logic        want_irq,
   // Requests to the block
   output logic             idle_req,
   output logic             sleep_req,
   output logic             irq_pending,
   // Activity counts, wrap freely
   output logic [15:0]      exec_cnt,
   output logic [15:0]      fetch_cnt,
   output logic [15:0]      periph_cnt
);
   // Requests change only after an edge, as a real core would
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         {idle_req, sleep_req, irq_pending} <= 3'h0;
         {exec_cnt, fetch_cnt, periph_cnt} <= 48'h0;
      end else begin
         idle_req    <= want_idle;
         sleep_req   <= want_sleep;
         irq_pending <= want_irq;
         exec_cnt    <= exec_cnt + {15'h0, cpu_clk_en};
         fetch_cnt   <= fetch_cnt + {15'h0, flash_fetch_en};
         periph_cnt  <= periph_cnt + {15'h0, periph_clk_en};
      end
   end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the oscillator select and CPU throttle block
`timescale 1ns/100ps
`include "oft_defines.svh"
module tb_top
   import oft_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  reset_osc_config = 3'h0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, r;
   logic        pready, pslverr, err, osc_run, cpu_clk_en, flash_fetch_en;
   logic        periph_clk_en, idle_req, sleep_req, irq_pending;
   logic [2:0]  hf_freq_code, cfg;
   logic [5:0]  hf_freq_mhz;
   logic [1:0]  periph_phase, power_mode;
   logic        want_idle = 1'b0;
   logic        want_sleep = 1'b0;
   logic        want_irq = 1'b0;
   logic [15:0] exec_cnt, fetch_cnt, periph_cnt;
   int          n_mismatch = 0;
   int          checked = 0;
   int          seed = 79;
   logic [5:0]  mhz_tab [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0C, 6'h10,
                                6'h20, 6'h00};

   always #20 sys_clk = ~sys_clk;

   oft_clock_ctrl oft_clock_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .reset_osc_config(reset_osc_config), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idle_req(idle_req),
      .sleep_req(sleep_req), .irq_pending(irq_pending), .osc_run(osc_run),
      .hf_freq_code(hf_freq_code), .hf_freq_mhz(hf_freq_mhz),
      .cpu_clk_en(cpu_clk_en), .flash_fetch_en(flash_fetch_en),
      .periph_clk_en(periph_clk_en), .periph_phase(periph_phase),
      .power_mode(power_mode));
   oft_core_model oft_core_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .cpu_clk_en(cpu_clk_en), .flash_fetch_en(flash_fetch_en),
      .periph_clk_en(periph_clk_en), .want_idle(want_idle),
      .want_sleep(want_sleep), .want_irq(want_irq), .idle_req(idle_req),
      .sleep_req(sleep_req), .irq_pending(irq_pending),
      .exec_cnt(exec_cnt), .fetch_cnt(fetch_cnt), .periph_cnt(periph_cnt));

   // Strap codes other than the two named ones fall back to 4 MHz
   function automatic logic [2:0] exp_strap(input logic [2:0] c);
      return (c == 3'h0) ? 3'h6 : 3'h2;
   endfunction

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h exp %h", $time, s, x);
      end
   endtask

   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Read data and error stand in the access phase; taken at its edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(input logic [2:0] c);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      reset_osc_config <= c;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wait_mode(input logic [1:0] m);
      int n;
      n = 0;
      while (power_mode !== m && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(power_mode), 32'(m));
   endtask

   // Window of w edges; phases must step by one every clock
   task automatic measure(input int w, input int x);
      logic [15:0] e0, f0, p0;
      logic [1:0]  ph;
      int          bad;
      bad = 0;
      @(posedge sys_clk);
      {e0, f0, p0, ph} = {exec_cnt, fetch_cnt, periph_cnt, periph_phase};
      repeat (w) begin
         @(posedge sys_clk);
         if (periph_phase !== ph + 2'h1) bad++;
         ph = periph_phase;
      end
      chk(32'(exec_cnt - e0), 32'(x));
      chk(32'(fetch_cnt - f0), 32'(w));
      chk(32'(periph_cnt - p0), 32'(w));
      chk(32'(bad), 32'h0);
   endtask

   initial begin
      #(40 * 30000);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      for (int i = 0; i < 3; i++) begin
         cfg = (i == 0) ? 3'h6 : (i == 1) ? 3'h0 : 3'($random(seed)) | 3'h1;
         do_reset(cfg);
         chk(32'(hf_freq_code), 32'(exp_strap(cfg)));
         apb(1'b0, `OFT_OFF_FREQ_SEL, 32'h0);
         chk(32'(rd[2:0]), 32'(exp_strap(cfg)));
      end
      $display("strap test done");
      for (int c = 0; c < 8; c++) begin
         r = $random(seed);
         apb(1'b1, `OFT_OFF_FREQ_SEL, {r[31:3], 3'(c)});
         // The write lands at the access edge; look one edge later
         @(posedge sys_clk);
         chk(32'(hf_freq_code), 32'(c));
         chk(32'(hf_freq_mhz), 32'(mhz_tab[c]));
         apb(1'b0, `OFT_OFF_FREQ_SEL, 32'h0);
         chk(rd, 32'(c));
      end
      $display("frequency test done");
      r = $random(seed);
      apb(1'b1, `OFT_OFF_THROTTLE, {r[31:6], 2'h0, r[3:0]});
      measure(64, 64);
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, `OFT_OFF_THROTTLE, 32'h10 | c);
         repeat (8 << c) @(posedge sys_clk);
         measure(16 << c, 8);
         chk(32'(osc_run), 32'h1);
      end
      apb(1'b0, `OFT_OFF_STATUS, 32'h0);
      chk(32'(rd[1:0]), 32'(OFT_THROTTLE));
      $display("throttle test done");
      apb(1'b1, `OFT_OFF_THROTTLE, 32'h11);
      want_irq <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk(32'(power_mode), 32'(OFT_THROTTLE));
      want_irq <= 1'b0;
      apb(1'b1, `OFT_OFF_THROTTLE, 32'h31);
      wait_mode(OFT_THROTTLE);
      @(posedge sys_clk);
      want_irq <= 1'b1;
      wait_mode(OFT_RUN);
      apb(1'b0, `OFT_OFF_THROTTLE, 32'h0);
      chk(32'(rd[5:4]), 32'h2);
      want_irq <= 1'b0;
      want_idle <= 1'b1;
      wait_mode(OFT_IDLE);
      chk(32'(periph_clk_en), 32'h1);
      @(posedge sys_clk);
      want_sleep <= 1'b1;
      wait_mode(OFT_SLEEP);
      chk(32'(osc_run), 32'h0);
      @(posedge sys_clk);
      {want_idle, want_sleep} <= 2'h0;
      wait_mode(OFT_RUN);
      $display("mode test done");
      apb(1'b1, 12'h00C, 32'h5);
      chk(32'(err), 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      chk(rd, 32'h0);
      chk(32'(hf_freq_code), 32'(`OFT_FRQ_RESERVED));
      $display("unmapped test done");
      tally_and_finish();
   end
endmodule
